// *** logic/plc_message_handshake.sv ***
// top: plc message handshake with axi4-lite register slave
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
module plc_message_handshake #(
  parameter int in_count = 64, // number of plc input pins
  parameter int out_count = 64 // number of plc output pins
) (
  input wire logic mclk, // 250 MHz clock
  input wire logic rst_b, // async reset, active low
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  output logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  input wire logic [7:0] s_axi_araddr, // read address
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  input wire logic [in_count-1:0] plc_in, // plc digital inputs
  output logic [out_count-1:0] plc_out, // plc digital outputs
  output logic robot_stop, // robot stop, high holds production
  output logic tool_update, // pulse: tool data correction applied
  output logic restart_default, // pulse: new measurement in default configuration
  output logic irq // interrupt, level
);

  initial
    if (in_count < 32 || in_count > 256 || out_count < 33 || out_count > 256)
      $error("pin counts out of range");

  // ==========================================================
  // reset release
  logic [1:0] rst_pipe_r;
  logic rst_sync_b;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      rst_pipe_r <= 2'h0;
    else
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
  end
  assign rst_sync_b = rst_pipe_r[1];

  // ==========================================================
  // input selection and synchronising
  function automatic logic pick(input logic [in_count-1:0] v, input logic [7:0] sel);
    logic r;
    r = 1'b0;
    for (int i = 0; i < in_count; i++)
    begin
      if (sel == 8'(i))
        r = v[i];
    end
    return r;
  endfunction

  typedef struct packed {
    logic enable;
    logic [23:0] limit;
    logic [7:0] out0_sel;
    logic [7:0] out1_sel;
    logic [7:0] out2_sel;
    logic [7:0] ack_sel;
    logic [7:0] ans_sel;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    msg_hs_pkg::hs_state_t state;
    logic [2:0] code;
    logic last_answer;
    logic answered;
    logic ack_prev;
    logic stop;
    logic [15:0] tool_cnt;
    logic upd;
    logic rst_pulse;
    logic aw_taken;
    logic [7:0] aw_addr;
    logic w_taken;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] bresp;
  } top_state_t;

  top_state_t st_r;
  top_state_t st_nxt;
  logic [1:0] pins_sel;
  logic [1:0] pins_sync;
  logic ack_lvl;
  logic ans_lvl;
  // ack and answer routed through configurable input numbers
  assign pins_sel = {pick(plc_in, st_r.ans_sel), pick(plc_in, st_r.ack_sel)};

  msg_sync #(
    .width(2)
  ) u_sync (
    .mclk(mclk),
    .rst_sync_b(rst_sync_b),
    .async_in(pins_sel),
    .sync_out(pins_sync)
  );

  assign ack_lvl = pins_sync[0];
  assign ans_lvl = pins_sync[1];

  // ==========================================================
  // next state
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (s[b])
        r[b*8 +: 8] = d[b*8 +: 8];
    end
    return r;
  endfunction
  logic do_write;
  logic [31:0] wmerged;
  logic [2:0] ev;
  logic [31:0] map_word;
  logic [31:0] ctrl_word;
  always_comb
  begin
    st_nxt = st_r;
    ev = 3'h0;
    st_nxt.upd = 1'b0;
    st_nxt.rst_pulse = 1'b0;
    st_nxt.ack_prev = ack_lvl;
    map_word = {st_r.ans_sel[3:0] - msg_hs_pkg::in_base[3:0], st_r.ack_sel[3:0] - msg_hs_pkg::in_base[3:0],
      st_r.out2_sel, st_r.out1_sel, st_r.out0_sel};
    ctrl_word = {31'h0, st_r.enable};
    wmerged = 32'h0;

    // handshake machine
    unique case (st_r.state)
      msg_hs_pkg::st_idle:
        st_nxt.code = 3'(msg_hs_pkg::res_ok);
      msg_hs_pkg::st_pending:
      begin
        if (ack_lvl && !st_r.ack_prev)
        begin
          st_nxt.state = msg_hs_pkg::st_wait_low;
          st_nxt.code = 3'(msg_hs_pkg::res_ok);
          st_nxt.last_answer = ans_lvl;
          st_nxt.answered = 1'b1;
          ev[msg_hs_pkg::irq_ack_bit] = 1'b1;
          if (st_r.code == 3'(msg_hs_pkg::res_manual))
          begin
            if (ans_lvl)
            begin
              st_nxt.upd = 1'b1;
              st_nxt.tool_cnt = st_r.tool_cnt + 16'h0001;
            end
            st_nxt.stop = 1'b0;
          end
          if (st_r.code == 3'(msg_hs_pkg::res_absolute))
            st_nxt.rst_pulse = 1'b1;
        end
        if (!st_r.enable)
        begin
          st_nxt.state = msg_hs_pkg::st_idle;
          st_nxt.code = 3'(msg_hs_pkg::res_ok);
        end
      end
      msg_hs_pkg::st_wait_low:
        if (!ack_lvl)
          st_nxt.state = msg_hs_pkg::st_idle;
    endcase

    // ==========================================================
    // axi4-lite slave
    if (s_axi_awvalid && s_axi_awready)
    begin
      st_nxt.aw_taken = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_nxt.w_taken = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready)
      st_nxt.bvalid = 1'b0;
    if (st_r.rvalid && s_axi_rready)
      st_nxt.rvalid = 1'b0;
    do_write = st_r.aw_taken && st_r.w_taken && !st_r.bvalid;
    if (do_write)
    begin
      st_nxt.aw_taken = 1'b0;
      st_nxt.w_taken = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = 2'h0;
      unique case ({st_r.aw_addr[7:2], 2'h0})
        msg_hs_pkg::ctrl_off:
        begin
          wmerged = merge(ctrl_word, st_r.w_data, st_r.w_strb);
          st_nxt.enable = wmerged[msg_hs_pkg::ctrl_enable_bit];
          if (wmerged[msg_hs_pkg::ctrl_default_cfg_bit])
            st_nxt.rst_pulse = 1'b1;
        end
        msg_hs_pkg::limit_off:
        begin
          wmerged = merge({8'h0, st_r.limit}, st_r.w_data, st_r.w_strb);
          st_nxt.limit = wmerged[23:0];
        end
        msg_hs_pkg::meas_off:
        begin
          if (st_r.w_data[msg_hs_pkg::meas_valid_bit] && st_r.state == msg_hs_pkg::st_idle)
          begin
            if (st_r.w_data[23:0] >= st_r.limit)
            begin
              st_nxt.stop = 1'b1;
              st_nxt.code = 3'(msg_hs_pkg::res_absolute);
            end
            else
            begin
              st_nxt.code = st_r.w_data[msg_hs_pkg::meas_code_lsb +: 3];
              st_nxt.stop = (st_r.w_data[msg_hs_pkg::meas_code_lsb +: 3] != 3'(msg_hs_pkg::res_ok));
            end
            if (st_nxt.code != 3'(msg_hs_pkg::res_ok))
            begin
              ev[msg_hs_pkg::irq_stop_bit] = 1'b1;
              if (st_r.enable)
              begin
                st_nxt.state = msg_hs_pkg::st_pending;
                st_nxt.answered = 1'b0;
                ev[msg_hs_pkg::irq_msg_bit] = 1'b1;
              end
            end
            if (!st_r.enable)
              st_nxt.code = 3'(msg_hs_pkg::res_ok);
          end
        end
        msg_hs_pkg::irq_stat_off:
          st_nxt.irq_stat = st_r.irq_stat & ~st_r.w_data[2:0];
        msg_hs_pkg::irq_mask_off:
          st_nxt.irq_mask = st_r.w_strb[0] ? st_r.w_data[2:0] : st_r.irq_mask;
        msg_hs_pkg::map_off:
        begin
          wmerged = merge(map_word, st_r.w_data, st_r.w_strb);
          st_nxt.out0_sel = wmerged[msg_hs_pkg::map_out0_lsb +: 8];
          st_nxt.out1_sel = wmerged[msg_hs_pkg::map_out1_lsb +: 8];
          st_nxt.out2_sel = wmerged[msg_hs_pkg::map_out2_lsb +: 8];
          st_nxt.ack_sel = msg_hs_pkg::in_base + {4'h0, wmerged[msg_hs_pkg::map_ack_lsb +: 4]};
          st_nxt.ans_sel = msg_hs_pkg::in_base + {4'h0, wmerged[msg_hs_pkg::map_ans_lsb +: 4]};
        end
        msg_hs_pkg::status_off:
          st_nxt.stop = st_r.stop & ~st_r.w_data[0];
        default:
          st_nxt.bresp = 2'h2;
      endcase
    end
    // hardware set wins over software clear
    st_nxt.irq_stat = st_nxt.irq_stat | ev;
    if (s_axi_arvalid && s_axi_arready)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = 2'h0;
      unique case ({s_axi_araddr[7:2], 2'h0})
        msg_hs_pkg::ctrl_off: st_nxt.rdata = ctrl_word;
        msg_hs_pkg::limit_off: st_nxt.rdata = {8'h0, st_r.limit};
        msg_hs_pkg::meas_off: st_nxt.rdata = 32'h0;
        msg_hs_pkg::status_off: st_nxt.rdata = {26'h0, st_r.answered, st_r.last_answer, 1'b0,
          st_r.state == msg_hs_pkg::st_pending, 1'b0, st_r.stop};
        msg_hs_pkg::irq_stat_off: st_nxt.rdata = {29'h0, st_r.irq_stat};
        msg_hs_pkg::irq_mask_off: st_nxt.rdata = {29'h0, st_r.irq_mask};
        msg_hs_pkg::map_off: st_nxt.rdata = map_word;
        msg_hs_pkg::result_off: st_nxt.rdata = {29'h0, st_r.code};
        msg_hs_pkg::tool_off: st_nxt.rdata = {16'h0, st_r.tool_cnt};
        default:
        begin
          st_nxt.rdata = 32'h0;
          st_nxt.rresp = 2'h2;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      st_r <= '0;
      st_r.enable <= msg_hs_pkg::plc_link_enable_rst;
      st_r.limit <= msg_hs_pkg::limit_rst;
      st_r.out0_sel <= msg_hs_pkg::out0_sel_rst;
      st_r.out1_sel <= msg_hs_pkg::out1_sel_rst;
      st_r.out2_sel <= msg_hs_pkg::out2_sel_rst;
      st_r.ack_sel <= msg_hs_pkg::ack_sel_rst;
      st_r.ans_sel <= msg_hs_pkg::ans_sel_rst;
    end
    else
      st_r <= st_nxt;
  end

  // ==========================================================
  // outputs
  assign s_axi_awready = !st_r.aw_taken;
  assign s_axi_wready = !st_r.w_taken;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign robot_stop = st_r.stop;
  assign tool_update = st_r.upd;
  assign restart_default = st_r.rst_pulse;
  assign irq = |(st_r.irq_stat & st_r.irq_mask);

  // result bits driven onto configurable output numbers
  always_comb
  begin
    plc_out = '0;
    for (int i = 0; i < out_count; i++)
    begin
      if (st_r.out0_sel == 8'(i))
        plc_out[i] = st_r.code[0];
      if (st_r.out1_sel == 8'(i))
        plc_out[i] = st_r.code[1];
      if (st_r.out2_sel == 8'(i))
        plc_out[i] = st_r.code[2];
    end
  end

endmodule

// *** logic/msg_hs_pkg.sv ***
// package: constants, types and register map of the plc message handshake
//
// Overview of operation
// - deviation at limit or above stops robot
// - messages out on three outputs, closed by two inputs
// - handshake active only when enable set, default off
// - three-bit binary result code, bit 2 msb
// - codes 0-3: ok, manual, absolute, no object
// - codes 4-7: diverge, z max, comm, unit
// - only code 1 needs yes/no, others acknowledge
// - result bits map to outputs, default 30 31 32
// - acknowledge closes the pending message at once
// - answer high means yes, low means no
// - acknowledge and answer map to inputs 30, 31
// - absolute error acknowledged starts default measurement
// - manual range yes updates tool data, no keeps
package msg_hs_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] limit_off = 8'h04;
  localparam logic [7:0] meas_off = 8'h08;
  localparam logic [7:0] status_off = 8'h0c;
  localparam logic [7:0] irq_stat_off = 8'h10;
  localparam logic [7:0] irq_mask_off = 8'h14;
  localparam logic [7:0] map_off = 8'h18;
  localparam logic [7:0] result_off = 8'h1c;
  localparam logic [7:0] tool_off = 8'h20;

  // ==========================================================
  // field positions
  localparam int ctrl_enable_bit = 0;
  localparam int ctrl_default_cfg_bit = 1;
  localparam int map_out0_lsb = 0;
  localparam int map_out1_lsb = 8;
  localparam int map_out2_lsb = 16;
  localparam int map_ack_lsb = 24;
  localparam int map_ans_lsb = 28;
  localparam int meas_valid_bit = 31;
  localparam int meas_code_lsb = 24;

  // ==========================================================
  // reset values
  localparam logic plc_link_enable_rst = 1'b0;
  localparam logic [7:0] out0_sel_rst = 8'h1e;
  localparam logic [7:0] out1_sel_rst = 8'h1f;
  localparam logic [7:0] out2_sel_rst = 8'h20;
  localparam logic [7:0] ack_sel_rst = 8'h1e;
  localparam logic [7:0] ans_sel_rst = 8'h1f;
  localparam logic [23:0] limit_rst = 24'h001388;
  localparam logic [7:0] out_base = 8'h1e;
  localparam logic [7:0] in_base = 8'h1e;

  // ==========================================================
  // irq bits
  localparam int irq_msg_bit = 0;
  localparam int irq_ack_bit = 1;
  localparam int irq_stop_bit = 2;

  // ==========================================================
  // result codes
  typedef enum logic [2:0] {
    res_ok, res_manual, res_absolute, res_no_object,
    res_no_converge, res_z_max, res_comm_err, res_unit_err
  } result_t;

  typedef enum logic [1:0] {st_idle, st_pending, st_wait_low} hs_state_t;

  typedef struct packed {
    logic yes;
    logic no;
    logic restart;
  } decision_t;

endpackage

// *** logic/msg_sync.sv ***
// three-stage synchroniser with agreement check on last two stages
module msg_sync #(
  parameter int width = 2
) (
  input wire logic mclk, // clock
  input wire logic rst_sync_b, // synchronous-released reset, active low
  input wire logic [width-1:0] async_in, // pin inputs
  output logic [width-1:0] sync_out // filtered level
);

  initial
  begin
    if (width < 1)
      $error("width must be at least 1");
  end

  typedef struct packed {
    logic [width-1:0] s1;
    logic [width-1:0] s2;
    logic [width-1:0] s3;
    logic [width-1:0] q;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < width; i++)
    begin
      if (st_r.s2[i] == st_r.s3[i])
        st_nxt.q[i] = st_r.s3[i];
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign sync_out = st_r.q;

endmodule

// *** bench/plc_msg_props.sv ***
// checker: concurrent properties on the plc handshake top ports
module plc_msg_props #(
  parameter int in_count = 64, // plc input count
  parameter int out_count = 64 // plc output count
) (
  input wire logic mclk, // clock
  input wire logic rst_b, // reset, active low
  input wire logic [in_count-1:0] plc_in, // plc inputs
  input wire logic [out_count-1:0] plc_out, // plc outputs
  input wire logic robot_stop, // robot stop level
  input wire logic tool_update, // tool update pulse
  input wire logic restart_default // restart pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] code;
  logic [out_count-1:0] other;
  assign code = plc_out[32:30];
  assign other = {plc_out[out_count-1:33], 3'h0, plc_out[29:0]};

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // ==========================================================
  // sequences
  sequence msg_post;
    code == 3'h0 ##1 code != 3'h0;
  endsequence
  sequence ack_rise;
    code != 3'h0 && $rose(plc_in[30]);
  endsequence
  sequence msg_close;
    code != 3'h0 ##1 code == 3'h0;
  endsequence

  // ==========================================================
  // properties
  a_other_quiet: assert property (other == '0)
    else $error("output outside the result bits driven");
  a_code_hold: assert property (code != 3'h0 && !plc_in[30] |=> $stable(code))
    else $error("result code moved while pending");
  a_code_clear: assert property (ack_rise |-> ##[2:8] code == 3'h0)
    else $error("result code not cleared after acknowledge");
  a_close_by_ack: assert property (msg_close |-> plc_in[30])
    else $error("message closed without acknowledge");
  a_stop_raise: assert property (msg_post |-> ##[0:3] robot_stop)
    else $error("posted message without robot stop");
  a_tool_single: assert property (tool_update |=> !tool_update)
    else $error("tool update longer than one cycle");
  a_tool_yes: assert property (tool_update |-> plc_in[31] && plc_in[30])
    else $error("tool update without yes answer");
  a_restart_single: assert property (restart_default |=> !restart_default)
    else $error("restart pulse longer than one cycle");
endmodule

// *** bench/plc_model.sv ***
// partner: plc side of the discrete message handshake
module plc_model (
  input wire logic mclk, // clock
  input wire logic [2:0] code, // result code from the device
  input wire logic ans_yes, // answer to give
  input wire logic [7:0] slow, // cycles before acknowledge, less one
  output logic ack, // acknowledge line
  output logic ans // answer line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    ack = 1'b0;
    ans = 1'b0;
    forever
    begin
      @(posedge mclk);
      if (code == 3'h0)
        ans <= ~ans; // answer carries nothing outside a dialog
      else
      begin
        ans <= ans_yes;
        repeat (slow + 1) @(posedge mclk);
        ack <= 1'b1;
        while (code != 3'h0) @(posedge mclk);
        repeat (2) @(posedge mclk);
        ack <= 1'b0;
      end
    end
  end
endmodule

// *** bench/plc_message_handshake_tb_top.sv ***
// testbench: register access and plc handshake scenarios
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("mismatch t=%0t got %h exp %h", $time, g, e); end end

module plc_message_handshake_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, slow;
  logic [31:0] wdata, rdata, rd_d;
  logic [1:0] bresp, rresp, rd_r, wr_r;
  logic [63:0] plc_in, plc_out;
  logic robot_stop, tool_update, restart_default, irq, ack, ans, ans_yes;
  int n_errors, cmp_count, n_tool, n_restart;
  assign plc_in = {32'h0, ans, ack, 30'h0};

  plc_message_handshake dut (.mclk(mclk), .rst_b(rst_b), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .plc_in(plc_in), .plc_out(plc_out),
    .robot_stop(robot_stop), .tool_update(tool_update), .restart_default(restart_default), .irq(irq));
  plc_model pm (.mclk(mclk), .code(plc_out[32:30]), .ans_yes(ans_yes), .slow(slow), .ack(ack), .ans(ans));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    if (tool_update === 1'b1)
      n_tool++;
    if (restart_default === 1'b1)
      n_restart++;
  end

  // ==========================================================
  // closing and bounded waits
  task automatic stop_test();
    $display("counts: mismatches %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic tmo(input int k);
    if (k > 200)
    begin
      n_errors++;
      $display("timeout t=%0t", $time);
      stop_test();
    end
  endtask

  // ==========================================================
  // bus cycles, ready and answers sampled where settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    int k;
    k = 0;
    bh = 1'b0;
    @(posedge mclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (!bh)
    begin
      @(negedge mclk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid;
      wr_r = bresp;
      @(posedge mclk);
      if (ah)
        awvalid <= 1'b0;
      if (wh)
        wvalid <= 1'b0;
      k++;
      tmo(k);
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    logic ah, rh;
    int k;
    k = 0;
    rh = 1'b0;
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!rh)
    begin
      @(negedge mclk);
      ah = arvalid & arready;
      rh = rvalid;
      rd_d = rdata;
      rd_r = rresp;
      @(posedge mclk);
      if (ah)
        arvalid <= 1'b0;
      k++;
      tmo(k);
    end
    rready <= 1'b0;
  endtask

  task automatic wait_code(input logic [2:0] e);
    int k;
    k = 0;
    @(negedge mclk);
    while (plc_out[32:30] !== e)
    begin
      @(negedge mclk);
      k++;
      tmo(k);
    end
  endtask

  // one message: post, let the plc close it, check and clear
  task automatic msg(input logic [2:0] c, input logic [23:0] dev, input logic y, input logic [2:0] e,
    input logic im);
    ans_yes <= y;
    slow <= {5'h0, c} * 8'h03;
    wr(msg_hs_pkg::meas_off, {1'b1, 4'h0, c, dev});
    wait_code(e);
    `CHK(plc_out[32:30], e)
    wait_code(3'h0);
    `CHK(irq, im)
    rd(msg_hs_pkg::status_off);
    `CHK(rd_d[0], e != 3'h1)
    if (e == 3'h1)
      `CHK(rd_d[5:4], {1'b1, y})
    wr(msg_hs_pkg::status_off, 32'h1);
    wr(msg_hs_pkg::irq_stat_off, 32'h7);
    @(negedge mclk);
    `CHK({irq, robot_stop}, 2'h0)
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    rst_b = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, ans_yes} = '0;
    {awaddr, araddr, slow, wdata} = '0;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(msg_hs_pkg::ctrl_off);
    `CHK(rd_d[0], 1'b0)
    rd(msg_hs_pkg::map_off);
    `CHK(rd_d, 32'h10201f1e)
    rd(8'hfc);
    `CHK(rd_r, 2'h2)
    `CHK(plc_out, 64'h0)
    wr(8'hfc, 32'h0);
    `CHK(wr_r, 2'h2)
    wr(msg_hs_pkg::map_off, 32'h10201f1e);
    `CHK(wr_r, 2'h0)
    rd(msg_hs_pkg::map_off);
    `CHK(rd_d, 32'h10201f1e)
    $display("test reset_values done");
    wr(msg_hs_pkg::irq_mask_off, 32'h7);
    wr(msg_hs_pkg::ctrl_off, 32'h1);
    for (int c = 1; c < 8; c++)
      msg(c[2:0], 24'h000010, 1'b1, c[2:0], 1'b1);
    rd(msg_hs_pkg::tool_off);
    `CHK(rd_d, 32'h1)
    `CHK({n_tool, n_restart}, {32'd1, 32'd1})
    $display("test all_codes done");
    msg(3'h1, 24'h001387, 1'b0, 3'h1, 1'b1);
    rd(msg_hs_pkg::tool_off);
    `CHK(rd_d, 32'h1)
    msg(3'h0, 24'h001388, 1'b1, 3'h2, 1'b1);
    `CHK({n_tool, n_restart}, {32'd1, 32'd2})
    wr(msg_hs_pkg::ctrl_off, 32'h3);
    @(negedge mclk);
    `CHK({n_tool, n_restart}, {32'd1, 32'd3})
    $display("test limit_and_answer done");
    wr(msg_hs_pkg::irq_mask_off, 32'h0);
    msg(3'h3, 24'h000010, 1'b1, 3'h3, 1'b0);
    $display("test irq_mask done");
    wr(msg_hs_pkg::ctrl_off, 32'h0);
    wr(msg_hs_pkg::meas_off, {1'b1, 4'h0, 3'h3, 24'h000010});
    repeat (20) @(posedge mclk);
    `CHK(plc_out[32:30], 3'h0)
    $display("test disabled done");
    stop_test();
  end
endmodule

bind plc_message_handshake plc_msg_props #(.in_count(in_count), .out_count(out_count)) props (.mclk(mclk),
  .rst_b(rst_b), .plc_in(plc_in), .plc_out(plc_out), .robot_stop(robot_stop), .tool_update(tool_update),
  .restart_default(restart_default));
